//--- core/cpu_port_regs.vh
`ifndef CPU_PORT_REGS_VH
`define CPU_PORT_REGS_VH
// ****************************************************************
// host port constants
// ****************************************************************
`define DATA_W        8
`define ADDR_W        10
`define ADDR_ZERO     10'h000
`define DATA_ZERO     8'h00
`define IRQ_W         8
`define IRQ_ZERO      8'h00
// ack stages: address/control captured, memory read, ack
`define ACK_DELAY     2'h2
`define CNT_ZERO      2'h0
// synchroniser idle: chip select high, all other control pins low
`define CTL_IDLE      6'h20
`endif

//--- core/cpu_parallel_port.v
`timescale 1ns/1ps
`default_nettype none
`include "cpu_port_regs.vh"
module cpu_parallel_port (
    input  wire                 SYS_CLK,
    input  wire                 NRST,
    input  wire                 CS_N,
    input  wire                 ADDR_LATCH_STROBE,
    input  wire                 BUS_MUX_SELECT,
    input  wire                 STROBE_STYLE,
    input  wire                 HOST_STROBE,
    input  wire                 HOST_DIR,
    input  wire [`ADDR_W-1:0]   HOST_ADDR_LINES,
    input  wire [`DATA_W-1:0]   HOST_DATA_IN,
    output reg  [`DATA_W-1:0]   HOST_DATA_OUT,
    output wire                 HOST_DATA_OE_N,
    output wire                 TRANSFER_ACK_OUT,
    output wire                 TRANSFER_ACK_OE_N,
    output wire                 IRQ_OUT,
    output wire                 IRQ_OE_N,
    input  wire [`IRQ_W-1:0]    IRQ_STATUS,
    input  wire [`IRQ_W-1:0]    IRQ_ENABLE,
    output reg  [`ADDR_W-1:0]   MEM_ADDR,
    output reg  [`DATA_W-1:0]   MEM_WDATA,
    output reg                  MEM_WR,
    output reg                  MEM_RD,
    input  wire [`DATA_W-1:0]   MEM_RDATA
);
    // ****************************************************************
    // overview
    // ****************************************************************
    // the host side is asynchronous to SYS_CLK, so every control pin,
    // the address lines and the data lines pass two flops first; the
    // cost is two cycles of latency before a request is seen
    // data and address ride the same sync depth as the strobes, so a
    // host that sets data together with its strobe is captured cleanly
    // one memory access is made per strobe; the sequencer will not
    // start another until the synced strobe or select has gone idle
    // open-drain pins are modelled as a constant low value plus an
    // active-low enable; the board pull-ups supply the high level
    // interrupt gating is plain combinational logic on same-clock
    // inputs, so it needs no synchroniser
    // ****************************************************************
    // pin synchronisers
    // ****************************************************************
    // control pins are from the host's timing, so two flops each
    localparam CW = 6;
    wire [CW-1:0] ctl_raw = {CS_N, ADDR_LATCH_STROBE, BUS_MUX_SELECT,
                             STROBE_STYLE, HOST_STROBE, HOST_DIR};
    reg  [CW-1:0] ctl_m_q;                 // first stage, read only by ctl_s_q
    reg  [CW-1:0] ctl_s_q;                 // second stage
    reg  [`ADDR_W-1:0] addr_m_q;           // address first stage
    reg  [`ADDR_W-1:0] addr_s_q;
    reg  [`DATA_W-1:0] din_m_q;            // data first stage
    reg  [`DATA_W-1:0] din_s_q;

    // both stages reset to idle (chip select high)
    always @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) begin
            ctl_m_q  <= `CTL_IDLE;
            ctl_s_q  <= `CTL_IDLE;
            addr_m_q <= `ADDR_ZERO;
            addr_s_q <= `ADDR_ZERO;
            din_m_q  <= `DATA_ZERO;
            din_s_q  <= `DATA_ZERO;
        end else begin
            ctl_m_q  <= ctl_raw;
            ctl_s_q  <= ctl_m_q;
            addr_m_q <= HOST_ADDR_LINES;
            addr_s_q <= addr_m_q;
            din_m_q  <= HOST_DATA_IN;
            din_s_q  <= din_m_q;
        end
    end

    wire cs_n   = ctl_s_q[5];
    wire as_in  = ctl_s_q[4];
    wire muxed  = ctl_s_q[3];
    wire style  = ctl_s_q[2];              // high: strobe/read-write style
    wire strb   = ctl_s_q[1];
    wire dir    = ctl_s_q[0];

    // ****************************************************************
    // cycle decode
    // ****************************************************************
    reg rd_act;                            // read cycle in progress
    reg wr_act;                            // write cycle in progress
    // decode per bus style; everything gated by chip select
    // the style pin only matters in multiplexed mode; non-muxed buses
    // always use an active-low strobe with a read/write select
    // limitation: the decode trusts the host to keep strobe and
    // direction steady for the whole access once they are asserted
    always @* begin
        rd_act = 1'b0;
        wr_act = 1'b0;
        if (!cs_n) begin
            if (!muxed) begin
                // active-low strobe, dir high means read
                rd_act = !strb && dir;
                wr_act = !strb && !dir;
            end else if (style) begin
                // muxed strobe style: high strobe, dir is read/write
                rd_act = strb && dir;
                wr_act = strb && !dir;
            end else begin
                // muxed read/write strobes, both active low
                rd_act = !strb;
                wr_act = !dir && strb;
            end
        end
    end

    // ****************************************************************
    // address latch
    // ****************************************************************
    reg [`DATA_W-1:0] alat_q;              // latched low address byte
    // transparent while strobe high, holds after fall; mode gated
    always @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) begin
            alat_q <= `DATA_ZERO;
        end else if (muxed && as_in) begin
            alat_q <= din_s_q;
        end
    end

    // upper address bits are zero in muxed mode, only eight lines exist
    wire [`ADDR_W-1:0] cur_addr = muxed ? {2'b00, alat_q} : addr_s_q;

    // ****************************************************************
    // transfer sequencer
    // ****************************************************************
    localparam S_IDLE = 2'd0;
    localparam S_BUSY = 2'd1;
    localparam S_ACK  = 2'd2;
    reg [1:0] st_q;                        // sequencer state
    reg [1:0] cnt_q;                       // wait count before ack
    reg       rd_q;                        // cycle is a read
    // one memory access per cycle, ack held until strobe drops
    // timing from the taking edge T:
    //   T    memory strobe and address registered
    //   T+1  read data returns and is copied to the pins
    //   T+3  wait count done, acknowledge asserted
    // the fixed wait keeps the ack behind the read data, at the price
    // of a slower cycle than the memory alone would need
    // a host that deselects early simply ends the ack phase sooner
    always @(posedge SYS_CLK or negedge NRST) begin
        if (!NRST) begin
            st_q          <= S_IDLE;
            cnt_q         <= `CNT_ZERO;
            rd_q          <= 1'b0;
            MEM_ADDR      <= `ADDR_ZERO;
            MEM_WDATA     <= `DATA_ZERO;
            MEM_WR        <= 1'b0;
            MEM_RD        <= 1'b0;
            HOST_DATA_OUT <= `DATA_ZERO;
        end else begin
            MEM_WR <= 1'b0;
            MEM_RD <= 1'b0;
            case (st_q)
                S_IDLE: begin
                    if (rd_act || wr_act) begin
                        st_q     <= S_BUSY;
                        cnt_q    <= `CNT_ZERO;
                        rd_q     <= rd_act;
                        MEM_ADDR <= cur_addr;
                        MEM_WDATA <= din_s_q;
                        MEM_RD   <= rd_act;
                        MEM_WR   <= wr_act;
                    end
                end
                S_BUSY: begin
                    // read data returns the cycle after the strobe
                    if (rd_q) begin
                        HOST_DATA_OUT <= MEM_RDATA;
                    end
                    if (cnt_q == `ACK_DELAY) begin
                        st_q <= S_ACK;
                    end else begin
                        cnt_q <= cnt_q + 2'd1;
                    end
                end
                S_ACK: begin
                    // leave when the host ends the cycle or deselects
                    if (!(rd_act || wr_act)) begin
                        st_q <= S_IDLE;
                    end
                end
                default: begin
                    st_q <= S_IDLE;
                end
            endcase
        end
    end

    // ****************************************************************
    // pin drivers
    // ****************************************************************
    // open drain: output value always low, enable low means driving
    // the ack enable comes straight from the state register, so it
    // cannot glitch; the data enable is combinational so that a host
    // which deselects early gets its bus back without a cycle of delay
    assign TRANSFER_ACK_OUT  = 1'b0;
    assign TRANSFER_ACK_OE_N = !(st_q == S_ACK);
    assign IRQ_OUT           = 1'b0;
    assign IRQ_OE_N          = !(|(IRQ_STATUS & IRQ_ENABLE));
    // drive data only during a live read; a late deselect releases at once
    assign HOST_DATA_OE_N    = !(rd_act && rd_q && st_q != S_IDLE);

endmodule
`default_nettype wire

//--- test/cpu_port_sva.sv
`timescale 1ns/1ps
`default_nettype none
// ****
// port checker
// ****
module cpu_port_sva (
    input wire logic       SYS_CLK,
    input wire logic       NRST,
    input wire logic       CS_N,
    input wire logic       BUS_MUX_SELECT,
    input wire logic       HOST_DATA_OE_N,
    input wire logic       TRANSFER_ACK_OE_N,
    input wire logic       IRQ_OE_N,
    input wire logic [7:0] IRQ_STATUS,
    input wire logic [7:0] IRQ_ENABLE,
    input wire logic [9:0] MEM_ADDR,
    input wire logic       MEM_WR,
    input wire logic       MEM_RD
);
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (!NRST);
    // six edges deselected covers the two-flop sync and the release edge
    sequence s_idle; CS_N[*6]; endsequence
    sequence s_go; MEM_RD || MEM_WR; endsequence
    a_cs_ignore: assert property (s_idle |=> !(MEM_RD || MEM_WR))
        else $error("access while deselected");
    a_bus_free: assert property (s_idle |-> TRANSFER_ACK_OE_N && HOST_DATA_OE_N)
        else $error("pins held while deselected");
    a_ack_delay: assert property (s_go |-> ##3 !TRANSFER_ACK_OE_N)
        else $error("ack late");
    a_irq_gate: assert property (IRQ_OE_N == !(|(IRQ_STATUS & IRQ_ENABLE)))
        else $error("irq gating wrong");
    a_rd_drive: assert property (MEM_RD |=> !HOST_DATA_OE_N)
        else $error("read not driven");
    a_wr_input: assert property (MEM_WR |-> HOST_DATA_OE_N[*3])
        else $error("write drives data");
    a_one_pulse: assert property (s_go |=> (!(MEM_RD || MEM_WR))[*4])
        else $error("repeat access");
    a_mux_addr: assert property (BUS_MUX_SELECT && MEM_RD |-> MEM_ADDR[9:8] == 2'b00)
        else $error("muxed address high bits");
endmodule
`default_nettype wire

//--- test/host_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****
// host processor
// ****
module host_cpu_model (
    input  wire logic       clk,
    input  wire logic       ack_oe_n,
    input  wire logic       dat_oe_n,
    input  wire logic [7:0] dat_out,
    output var  logic       cs_n,
    output var  logic       als,
    output var  logic       stb,
    output var  logic       dir,
    output var  logic [9:0] addr,
    output wire logic [7:0] dat_in
);
    logic [7:0] drv_q; // value the host puts out
    logic       own_q; // host drives the data lines
    // no pull-up: a released line shows the inverse of the last value
    assign dat_in = !dat_oe_n ? dat_out : (own_q ? drv_q : ~drv_q);
    initial begin
        {cs_n, als, stb, dir, addr, drv_q, own_q} = {4'b1011, 10'h000, 8'h00, 1'b0};
    end
    // one access: latch phase, strobe held until ack, then release
    task automatic xfer(input logic m, s, rd, input logic [9:0] a, input logic [7:0] w,
                        output logic [7:0] r);
        int n;
        n = 0;
        @(posedge clk);
        {cs_n, stb, addr, als, own_q} <= {1'b0, !(m & s), a, 2'b11};
        drv_q <= m ? a[7:0] : ~a[7:0];
        repeat (4) @(posedge clk);
        als <= 1'b0;
        repeat (4) @(posedge clk);
        {drv_q, own_q, dir} <= {w, !rd, rd};
        stb <= m & s ? 1'b1 : (m ? !rd : 1'b0);
        while (ack_oe_n && n < 60) begin
            @(posedge clk);
            n++;
        end
        r = dat_in;
        {cs_n, stb, dir, own_q} <= {1'b1, !(m & s), 2'b10};
        repeat (8) @(posedge clk);
    endtask
endmodule
`default_nettype wire

//--- test/cpu_parallel_port_bench.sv
`timescale 1ns/1ps
`default_nettype none
// ****
// bench
// ****
module cpu_parallel_port_bench;
    typedef struct packed {logic m, s, rd; logic [9:0] a; logic [7:0] w;} row_t;
    logic       SYS_CLK = 0, NRST = 0, BUS_MUX_SELECT = 0, STROBE_STYLE = 1;
    logic       cs_n, als, stb, dir, d_oe_n, a_out, a_oe_n, i_out, i_oe_n, wr, rd;
    logic [9:0] haddr, maddr, wa;
    logic [7:0] din, dout, wdat, wd, got, st = 0, en = 0;
    int         n_fail = 0, num_checks = 0, pulses = 0;
    row_t       rows[6] = '{{3'b011, 10'h3ff, 8'h00}, {3'b010, 10'h000, 8'ha5},
        {3'b111, 10'h2c3, 8'h00}, {3'b110, 10'h155, 8'h3c}, {3'b101, 10'h0ff, 8'h00},
        {3'b100, 10'h001, 8'h81}};
    host_cpu_model host (.clk(SYS_CLK), .ack_oe_n(a_oe_n), .dat_oe_n(d_oe_n), .dat_out(dout),
        .cs_n(cs_n), .als(als), .stb(stb), .dir(dir), .addr(haddr), .dat_in(din));
    // memory answers with a pattern of its address
    cpu_parallel_port dut (.SYS_CLK(SYS_CLK), .NRST(NRST), .CS_N(cs_n), .ADDR_LATCH_STROBE(als),
        .BUS_MUX_SELECT(BUS_MUX_SELECT), .STROBE_STYLE(STROBE_STYLE), .HOST_STROBE(stb),
        .HOST_DIR(dir), .HOST_ADDR_LINES(haddr), .HOST_DATA_IN(din), .HOST_DATA_OUT(dout),
        .HOST_DATA_OE_N(d_oe_n), .TRANSFER_ACK_OUT(a_out), .TRANSFER_ACK_OE_N(a_oe_n),
        .IRQ_OUT(i_out), .IRQ_OE_N(i_oe_n), .IRQ_STATUS(st), .IRQ_ENABLE(en),
        .MEM_ADDR(maddr), .MEM_WDATA(wdat), .MEM_WR(wr), .MEM_RD(rd), .MEM_RDATA(maddr[7:0] ^ 8'h5a));
    initial forever #4 SYS_CLK = ~SYS_CLK;
    // capture what the memory side saw
    always @(posedge SYS_CLK) begin
        if (wr | rd) begin
            {wa, wd} <= {maddr, wdat};
            pulses++;
        end
    end
    task automatic chk(input string nm, input logic [17:0] seen, exp);
        num_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge SYS_CLK);
        chk("reset", {d_oe_n, a_oe_n, a_out, wr, rd}, 5'b11000);
        NRST <= 1;
        foreach (rows[i]) begin
            {BUS_MUX_SELECT, STROBE_STYLE} <= {rows[i].m, rows[i].s};
            host.xfer(rows[i].m, rows[i].s, rows[i].rd, rows[i].a, rows[i].w, got);
            chk("access", {wa, rows[i].rd ? got : wd}, {rows[i].m ? {2'h0, rows[i].a[7:0]} :
                rows[i].a, rows[i].rd ? rows[i].a[7:0] ^ 8'h5a : rows[i].w});
        end
        // strobe active with select high must start nothing
        pulses = 0;
        host.stb <= 1'b0;
        repeat (20) @(posedge SYS_CLK);
        chk("deselected", 18'(pulses), 18'h0_0000);
        chk("desel_pins", {d_oe_n, a_oe_n}, 2'b11);
        for (int k = 0; k < 8; k++) begin
            {st, en} <= {8'h01 << k, 8'h0f};
            @(posedge SYS_CLK);
            #1 chk("irq", {i_out, i_oe_n}, k < 4 ? 2'b00 : 2'b01);
        end
        finish_test;
    end
    initial begin
        repeat (5000) @(posedge SYS_CLK);
        n_fail++;
        finish_test;
    end
endmodule
bind cpu_parallel_port cpu_port_sva chk_i (.SYS_CLK(SYS_CLK), .NRST(NRST), .CS_N(CS_N),
    .BUS_MUX_SELECT(BUS_MUX_SELECT), .HOST_DATA_OE_N(HOST_DATA_OE_N), .IRQ_OE_N(IRQ_OE_N),
    .TRANSFER_ACK_OE_N(TRANSFER_ACK_OE_N), .IRQ_STATUS(IRQ_STATUS), .IRQ_ENABLE(IRQ_ENABLE),
    .MEM_ADDR(MEM_ADDR), .MEM_WR(MEM_WR), .MEM_RD(MEM_RD));
`default_nettype wire
